// >>> design/dcl_ctrl_top.sv
// The strobed register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module dcl_ctrl_top
  import dcl_pkg::*;
(
  input  wire logic              mclk_in,        // Clock, 40 MHz
  input  wire logic              rst_b_in,       // Async reset, active low
  input  wire logic [ADDR_W-1:0] addr_in,        // Register byte address
  input  wire logic [31:0]       wdata_in,       // Write data
  input  wire logic              wr_in,          // Write strobe
  input  wire logic              rd_in,          // Read strobe
  output logic      [31:0]       rdata_out,      // Read data, next cycle
  input  wire logic              nvm_valid_in,   // NVM defaults are valid
  input  wire logic              nvm_duplex_in,  // NVM duplex default
  input  wire logic              nvm_wake_in,    // NVM wake power enable
  input  wire logic              req_in,         // Function master request
  input  wire logic              mng_req_in,     // Manageability request
  input  wire logic              done_in,        // Master request completed
  output logic                   req_out,        // Gated function request
  output logic                   mng_req_out,    // Gated manageability request
  input  wire logic              phy_link_in,    // PHY link indication
  input  wire logic [1:0]        phy_speed_in,   // PHY speed
  input  wire logic [1:0]        det_speed_in,   // MAC detected speed
  output logic                   link_up_out,    // Link recognized
  output logic                   data_en_out,    // Data path enable
  output logic                   full_dup_out,   // Duplex to MAC
  output logic      [1:0]        speed_out,      // Speed to MAC
  output logic      [12:0]       rxfh_out        // Rx FIFO head pointer
);

  ////////////////////////////////////////////////////////////////////////
  // Decode
  logic       hit_ctrl;
  logic       hit_rxfh;
  logic       hit_stat;
  logic [7:0] ctrl_reg;
  logic [12:0] rxfh_reg;
  logic       idle;
  dcl_state_t state_reg;

  assign hit_ctrl = (addr_in == CTRL_OFS) || (addr_in == CTRL_ALIAS_OFS);
  assign hit_rxfh = (addr_in == RXFH_OFS) || (addr_in == RXFH_ALIAS_OFS);
  assign hit_stat = (addr_in == STAT_OFS);

  ////////////////////////////////////////////////////////////////////////
  // Reset sequencing: NVM defaults are captured after release,
  // never in the async branch
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= DCL_BOOT;
    end else begin
      unique case (state_reg)
        DCL_BOOT: state_reg <= DCL_LOAD;
        DCL_LOAD: if (nvm_valid_in) state_reg <= DCL_RUN;
        DCL_RUN:  state_reg <= DCL_RUN;
        default:  state_reg <= DCL_BOOT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control byte; reserved bits simply store what was written
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctrl_reg <= CTRL_RST_BASE;
    end else if (state_reg == DCL_LOAD && nvm_valid_in) begin
      ctrl_reg[DUPLEX_BIT] <= nvm_duplex_in;
      ctrl_reg[PERMIT_BIT] <= nvm_wake_in;
    end else if (wr_in && hit_ctrl) begin
      ctrl_reg <= wdata_in[7:0];
    end
  end

  // Rx FIFO head pointer, same storage at both offsets
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rxfh_reg <= RXFH_RST;
    end else if (wr_in && hit_rxfh) begin
      rxfh_reg <= wdata_in[12:0];
    end
  end
  assign rxfh_out = rxfh_reg;

  ////////////////////////////////////////////////////////////////////////
  // Read data valid only in the cycle after the strobe
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rdata_out <= 32'h0000_0000;
    end else if (rd_in) begin
      if (hit_ctrl)
        rdata_out <= {24'h00_0000, ctrl_reg};
      else if (hit_rxfh)
        rdata_out <= {19'h0_0000, rxfh_reg};
      else if (hit_stat)
        rdata_out <= {31'h0000_0000, idle};
      else
        rdata_out <= 32'h0000_0000;
    end else begin
      rdata_out <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Submodules
  dcl_master_gate u_master (
    .mclk_in     (mclk_in),
    .rst_b_in    (rst_b_in),
    .block_in    (ctrl_reg[BLOCK_BIT]),
    .req_in      (req_in),
    .mng_req_in  (mng_req_in),
    .done_in     (done_in),
    .req_out     (req_out),
    .mng_req_out (mng_req_out),
    .idle_out    (idle)
  );

  dcl_link_gate u_link (
    .mclk_in      (mclk_in),
    .rst_b_in     (rst_b_in),
    .permit_in    (ctrl_reg[PERMIT_BIT]),
    .duplex_in    (ctrl_reg[DUPLEX_BIT]),
    .asd_in       (ctrl_reg[ASD_BIT]),
    .phy_link_in  (phy_link_in),
    .phy_speed_in (phy_speed_in),
    .det_speed_in (det_speed_in),
    .link_up_out  (link_up_out),
    .data_en_out  (data_en_out),
    .full_dup_out (full_dup_out),
    .speed_out    (speed_out)
  );

endmodule : dcl_ctrl_top
`default_nettype wire

// >>> design/dcl_pkg.sv
package dcl_pkg;

  localparam int ADDR_W = 20;
  localparam logic [19:0] CTRL_OFS       = 20'h0_0000;
  localparam logic [19:0] CTRL_ALIAS_OFS = 20'h0_0004;
  localparam logic [19:0] RXFH_OFS       = 20'h0_2410;
  localparam logic [19:0] RXFH_ALIAS_OFS = 20'h0_8000;
  localparam logic [19:0] STAT_OFS       = 20'h0_0008;

  localparam int DUPLEX_BIT = 0;
  localparam int BLOCK_BIT  = 2;
  localparam int ASD_BIT    = 5;
  localparam int PERMIT_BIT = 6;
  localparam int IDLE_BIT   = 0;

  // Byte reset value without the NVM-loaded bits; bit 3 resets to one
  localparam logic [7:0]  CTRL_RST_BASE = 8'h08;
  localparam logic [12:0] RXFH_RST      = 13'h0000;
  localparam logic [3:0]  PEND_MAX      = 4'hF;

  typedef enum logic [2:0] {
    DCL_BOOT = 3'b001,
    DCL_LOAD = 3'b010,
    DCL_RUN  = 3'b100
  } dcl_state_t;

endpackage : dcl_pkg

// >>> design/dcl_master_gate.sv
`timescale 1ns/1ps
`default_nettype none
module dcl_master_gate
  import dcl_pkg::*;
(
  input  wire logic mclk_in,      // Clock
  input  wire logic rst_b_in,     // Async reset, active low
  input  wire logic block_in,     // Block new master requests
  input  wire logic req_in,       // Master request from function
  input  wire logic mng_req_in,   // Master request from manageability
  input  wire logic done_in,      // One request completed
  output logic      req_out,      // Request passed to bus
  output logic      mng_req_out,  // Manageability request passed
  output logic      idle_out      // Blocked and nothing pending
);
  logic [3:0] pend_reg;
  logic       issue;
  logic [1:0] issue_cnt;
  logic [4:0] pend_sum;

  // Gate both request sources while blocked
  assign req_out     = req_in & ~block_in;
  assign mng_req_out = mng_req_in & ~block_in;
  assign issue       = req_out | mng_req_out;
  assign issue_cnt   = {1'b0, req_out} + {1'b0, mng_req_out};
  // One spare bit shows overflow; a stray completion at zero is caught before the sum
  assign pend_sum    = {1'b0, pend_reg} + {3'b000, issue_cnt} - {4'b0000, done_in};

  // Outstanding count; saturates so a stuck partner cannot wrap it
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pend_reg <= 4'h0;
    end else if (issue || done_in) begin
      if (done_in && pend_reg == 4'h0 && !issue)
        pend_reg <= 4'h0;             // Completion with nothing pending is ignored
      else if (pend_sum > {1'b0, PEND_MAX})
        pend_reg <= PEND_MAX;
      else
        pend_reg <= pend_sum[3:0];
    end
  end

  // Idle only once blocked and all pending work drained
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      idle_out <= 1'b0;
    end else begin
      idle_out <= block_in && (pend_reg == 4'h0);
    end
  end
endmodule : dcl_master_gate
`default_nettype wire

// >>> design/dcl_link_gate.sv
`timescale 1ns/1ps
`default_nettype none
module dcl_link_gate (
  input  wire logic       mclk_in,       // Clock
  input  wire logic       rst_b_in,      // Async reset, active low
  input  wire logic       permit_in,     // Link-up permit
  input  wire logic       duplex_in,     // Duplex select, 1 full
  input  wire logic       asd_in,        // Auto speed detect enable
  input  wire logic       phy_link_in,   // PHY link-up indication
  input  wire logic [1:0] phy_speed_in,  // Speed reported by PHY
  input  wire logic [1:0] det_speed_in,  // Speed detected by MAC
  output logic            link_up_out,   // Link recognized by MAC
  output logic            data_en_out,   // Rx and Tx data allowed
  output logic            full_dup_out,  // MAC in full duplex
  output logic [1:0]      speed_out      // Speed MAC runs at
);
  // Registered so the MAC sees one clean level per cycle
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      link_up_out  <= 1'b0;
      data_en_out  <= 1'b0;
      full_dup_out <= 1'b0;
      speed_out    <= 2'b00;
    end else begin
      link_up_out  <= permit_in & phy_link_in;
      data_en_out  <= permit_in & phy_link_in;
      full_dup_out <= duplex_in;
      speed_out    <= asd_in ? det_speed_in : phy_speed_in;
    end
  end
endmodule : dcl_link_gate
`default_nettype wire

// >>> dv/dcl_ctrl_chk.sv
`timescale 1ns/1ps
`default_nettype none
module dcl_ctrl_chk
  import dcl_pkg::*;
(
  input wire logic              mclk_in,      // Clock
  input wire logic              rst_b_in,     // Reset
  input wire logic [ADDR_W-1:0] addr_in,      // Address
  input wire logic              wr_in,        // Write
  input wire logic              rd_in,        // Read
  input wire logic [31:0]       rdata_out,    // Read data
  input wire logic              req_in,       // Request
  input wire logic              mng_req_in,   // Mng request
  input wire logic              req_out,      // Gated request
  input wire logic              mng_req_out,  // Gated mng request
  input wire logic              phy_link_in,  // PHY link
  input wire logic [1:0]        phy_speed_in, // PHY speed
  input wire logic [1:0]        det_speed_in, // Detected speed
  input wire logic              link_up_out,  // Link up
  input wire logic              data_en_out,  // Data enable
  input wire logic              full_dup_out, // Duplex
  input wire logic [1:0]        speed_out     // Speed
);
  // Marks the answer cycle of a control read; outputs are judged against that byte
  logic rd_q, wr_q, rd_c_q;
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_q   <= 1'b0;
      wr_q   <= 1'b0;
      rd_c_q <= 1'b0;
    end else begin
      rd_q   <= rd_in;
      wr_q   <= wr_in;
      rd_c_q <= rd_in && (addr_in == CTRL_OFS || addr_in == CTRL_ALIAS_OFS);
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  default clocking dcl_cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);
  a_rd_idle_zero: assert property (!rd_q |-> rdata_out == 32'h0000_0000)
    else $error("read data not zero outside answer");
  a_ctrl_upper_zero: assert property (rd_c_q |-> rdata_out[31:8] == 24'h00_0000)
    else $error("control upper bits not zero");
  a_req_gated: assert property (rd_c_q |-> $past(req_out) == ($past(req_in) & ~rdata_out[2]))
    else $error("request not gated by block");
  a_mng_gated: assert property (rd_c_q |-> $past(mng_req_out) == ($past(mng_req_in) & ~rdata_out[2]))
    else $error("mng request not gated by block");
  a_duplex_out: assert property (rd_c_q && !wr_q |-> full_dup_out == rdata_out[0])
    else $error("duplex output wrong");
  a_link_permit: assert property (rd_c_q |-> link_up_out == (rdata_out[6] & $past(phy_link_in)))
    else $error("link up without permit");
  a_data_permit: assert property (rd_c_q |-> data_en_out == (rdata_out[6] & $past(phy_link_in)))
    else $error("data enable without permit");
  a_speed_sel: assert property (rd_c_q |->
    speed_out == (rdata_out[5] ? $past(det_speed_in) : $past(phy_speed_in)))
    else $error("speed source wrong");
  c_block: cover property (rd_c_q && rdata_out[2]);
  c_asd: cover property (rd_c_q && rdata_out[5]);
  c_link: cover property (link_up_out);
endmodule : dcl_ctrl_chk
`default_nettype wire

// >>> dv/tb_dcl_ctrl_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dcl_ctrl_top;
  import dcl_pkg::*;
  logic mclk_in, rst_b_in, wr_in, rd_in, nvm_valid_in, nvm_duplex_in, nvm_wake_in, req_in;
  logic mng_req_in, done_in, phy_link_in, req_out, mng_req_out, link_up_out, data_en_out;
  logic full_dup_out;
  logic [1:0] phy_speed_in, det_speed_in, speed_out;
  logic [ADDR_W-1:0] addr_in;
  logic [31:0] wdata_in, rdata_out;
  logic [12:0] rxfh_out;
  int n_fail, n_tests;
  // Rows: write address, write data, read address, expected read data
  logic [103:0] rows [5] = '{
    {20'h0_0000, 32'h0000_0049, 20'h0_0004, 32'h0000_0049},
    {20'h0_0004, 32'hFFFF_FF9A, 20'h0_0000, 32'h0000_009A},
    {20'h0_2410, 32'h1FFF_ABCD, 20'h0_8000, 32'h0000_0BCD},
    {20'h0_8000, 32'h0000_1234, 20'h0_2410, 32'h0000_1234},
    {20'h0_0100, 32'hFFFF_FFFF, 20'h0_0100, 32'h0000_0000}};
  dcl_ctrl_top dut (.mclk_in, .rst_b_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .nvm_valid_in, .nvm_duplex_in, .nvm_wake_in, .req_in, .mng_req_in, .done_in, .req_out,
    .mng_req_out, .phy_link_in, .phy_speed_in, .det_speed_in, .link_up_out, .data_en_out,
    .full_dup_out, .speed_out, .rxfh_out);
  //////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial begin
    mclk_in = 1'b0;
    forever #12.5 mclk_in = ~mclk_in;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [19:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge mclk_in);
    wr_in    <= 1'b0;
  endtask : wr
  // Data stands only in the cycle after the strobe, so it is sampled just past that edge
  task automatic rd(input logic [19:0] a, input logic [31:0] exp);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge mclk_in);
    rd_in   <= 1'b0;
    #1 chk(rdata_out, exp);
  endtask : rd
  // Four edges after release cover the boot and NVM load steps
  task automatic do_reset(input logic wake, input logic dup);
    rst_b_in      <= 1'b0;
    nvm_wake_in   <= wake;
    nvm_duplex_in <= dup;
    repeat (10) @(posedge mclk_in);
    rst_b_in      <= 1'b1;
    repeat (4) @(posedge mclk_in);
  endtask : do_reset
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report
  // Whole run is under a hundred cycles; the watchdog allows 2000
  initial begin
    #50000 n_fail++;
    final_report();
  end
  // Main sequence
  initial begin
    {wr_in, rd_in, req_in, mng_req_in, done_in, phy_link_in, nvm_valid_in} = 7'h01;
    {addr_in, wdata_in, phy_speed_in, det_speed_in} = {52'h0, 4'h6};
    do_reset(1'b0, 1'b1);
    rd(CTRL_OFS, 32'h0000_0009);
    for (int i = 0; i < 5; i++) begin
      wr(rows[i][103:84], rows[i][83:52]);
      rd(rows[i][51:32], rows[i][31:0]);
    end
    chk(32'(rxfh_out), 32'h0000_1234);
    @(posedge mclk_in);
    phy_link_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    #1 chk(32'(link_up_out), 32'h0000_0000);
    wr(CTRL_OFS, 32'h0000_0069);
    repeat (2) @(posedge mclk_in);
    #1 chk(32'({link_up_out, data_en_out, full_dup_out, speed_out}), 32'h0000_001E);
    rd(CTRL_ALIAS_OFS, 32'h0000_0069);
    wr(CTRL_ALIAS_OFS, 32'h0000_0048);
    repeat (2) @(posedge mclk_in);
    #1 chk(32'({link_up_out, data_en_out, full_dup_out, speed_out}), 32'h0000_0019);
    // One request from each source while open; both stay outstanding
    @(posedge mclk_in);
    req_in     <= 1'b1;
    mng_req_in <= 1'b1;
    @(posedge mclk_in);
    req_in     <= 1'b0;
    mng_req_in <= 1'b0;
    wr(CTRL_OFS, 32'h0000_000C);
    req_in     <= 1'b1;
    mng_req_in <= 1'b1;
    @(posedge mclk_in);
    #1 chk(32'({req_out, mng_req_out, link_up_out}), 32'h0000_0000);
    rd(STAT_OFS, 32'h0000_0000);
    // Two completions drain the two outstanding requests
    @(posedge mclk_in);
    done_in <= 1'b1;
    repeat (2) @(posedge mclk_in);
    done_in    <= 1'b0;
    req_in     <= 1'b0;
    mng_req_in <= 1'b0;
    rd(STAT_OFS, 32'h0000_0001);
    // Hold back the NVM defaults: the byte keeps its base reset value
    @(posedge mclk_in);
    nvm_valid_in <= 1'b0;
    do_reset(1'b1, 1'b0);
    rd(CTRL_ALIAS_OFS, 32'h0000_0008);
    @(posedge mclk_in);
    nvm_valid_in <= 1'b1;
    rd(CTRL_ALIAS_OFS, 32'h0000_0048);
    final_report();
  end
endmodule : tb_dcl_ctrl_top
bind dcl_ctrl_top dcl_ctrl_chk u_chk (.mclk_in, .rst_b_in, .addr_in, .wr_in, .rd_in, .rdata_out,
  .req_in, .mng_req_in, .req_out, .mng_req_out, .phy_link_in, .phy_speed_in, .det_speed_in,
  .link_up_out, .data_en_out, .full_dup_out, .speed_out);
`default_nettype wire
